// ### smbus_switch_params.svh
// Constants for the SMBus power-switch controller
`ifndef SMBUS_SWITCH_PARAMS_SVH
`define SMBUS_SWITCH_PARAMS_SVH

// Upper five bits of both channel addresses; then the address-select level, then the channel bit
`define CHAN_ADDR_HIGH   5'h14
`define CHAN_A_LSB       1'h0
`define CHAN_B_LSB       1'h1
`define POINTER_ADDR     7'h0c

// Command byte field positions
`define CMD_OP_BIT       7
`define CMD_SUP_ON_BIT   6
`define CMD_SUP_SRC_BIT  5
`define CMD_SUP_HIZ_BIT  4
`define CMD_PRG_ON_BIT   3
`define CMD_PRG_SRC_BIT  2
`define CMD_PRG_HIZ_BIT  1
`define CMD_MASK_BIT     0

// Reset values and byte geometry
`define CMD_RESET        8'h00
`define FAULT_RESET      5'h00
`define FAULT_TAIL       3'h0
`define POINTER_TAIL     1'h0
`define BIT_COUNT_RESET  4'h0
`define BIT_COUNT_ONE    4'h1
`define LAST_BIT_INDEX   4'h7
`define BYTE_BITS        4'h8

// Sync reset image: clock, data and suspend-select idle high, address select and faults low
`define SYNC_WIDTH       9
`define SYNC_INIT        9'h1c0

`endif

// ### smbus_switch_pkg.sv
// Types shared by the SMBus power-switch controller
package smbus_switch_pkg;

  typedef enum logic [1:0] {
    SUPPLY_GROUND = 2'b00,
    SUPPLY_FROM_X = 2'b01,
    SUPPLY_FROM_Y = 2'b10,
    SUPPLY_HIGHZ  = 2'b11
  } supply_mode_type;

  typedef enum logic [1:0] {
    PROG_GROUND    = 2'b00,
    PROG_FROM_CARD = 2'b01,
    PROG_FROM_12V  = 2'b10,
    PROG_HIGHZ     = 2'b11
  } program_mode_type;

  typedef struct packed {
    supply_mode_type  card_supply;
    program_mode_type program_supply;
  } switch_ctrl_type;

  typedef struct packed {
    logic catastrophic_fault;
    logic card_a_supply_fault;
    logic card_a_program_fault;
    logic card_b_supply_fault;
    logic card_b_program_fault;
  } fault_type;

  typedef enum logic [3:0] {
    BUS_IDLE    = 4'b0000,
    BUS_ADDR    = 4'b0001,
    BUS_ADDR_ACK= 4'b0010,
    BUS_WR_DATA = 4'b0011,
    BUS_WR_ACK  = 4'b0100,
    BUS_WR_DONE = 4'b0101,
    BUS_RD_DATA = 4'b0110,
    BUS_RD_ACK  = 4'b0111,
    BUS_IGNORE  = 4'b1000
  } bus_state_type;

  typedef enum logic [2:0] {
    TGT_NONE    = 3'b000,
    TGT_CMD_A   = 3'b001,
    TGT_CMD_B   = 3'b010,
    TGT_FAULTS  = 3'b011,
    TGT_POINTER = 3'b100
  } target_type;

endpackage

// ### pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  logic             CLK_SYS,
  input  logic             SYS_RST,
  input  logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  always_comb begin
    next_state    = state;
    next_state.s1 = pin_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    // Only stages two and three are compared; stage one may be metastable
    next_state.q  = (state.s2 == state.s3) ? state.s3 : state.q;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state <= {INIT, INIT, INIT, INIT};
    end else begin
      state <= next_state;
    end
  end

  assign pin_out = state.q;
endmodule

// ### switch_decode.sv
// Command byte to switch state decode for one socket
`timescale 1ns/1ns
`include "smbus_switch_params.svh"
module switch_decode (
  input  logic [7:0]                        cmd,
  output smbus_switch_pkg::switch_ctrl_type ctrl
);
  import smbus_switch_pkg::*;

  always_comb begin
    // High impedance overrides the on bit
    if (cmd[`CMD_SUP_HIZ_BIT]) begin
      ctrl.card_supply = SUPPLY_HIGHZ;
    end else if (cmd[`CMD_SUP_ON_BIT]) begin
      ctrl.card_supply = cmd[`CMD_SUP_SRC_BIT] ? SUPPLY_FROM_Y : SUPPLY_FROM_X;
    end else begin
      ctrl.card_supply = SUPPLY_GROUND;
    end
    if (cmd[`CMD_PRG_HIZ_BIT]) begin
      ctrl.program_supply = PROG_HIGHZ;
    end else if (cmd[`CMD_PRG_ON_BIT]) begin
      ctrl.program_supply = cmd[`CMD_PRG_SRC_BIT] ? PROG_FROM_12V : PROG_FROM_CARD;
    end else begin
      ctrl.program_supply = PROG_GROUND;
    end
  end
endmodule

// ### smbus_power_switch_ctrl.sv
// SMBus slave control logic of a dual-socket power switch
`timescale 1ns/1ns
`include "smbus_switch_params.svh"
module smbus_power_switch_ctrl (
  input  logic                              CLK_SYS,
  input  logic                              SYS_RST,
  input  logic                              SMB_CLK,
  input  logic                              SMB_DATA_IN,
  output logic                              SMB_DATA_OUT,
  output logic                              SMB_DATA_OE_N,
  output logic                              ALERT_OE_N,
  input  logic                              ADDRESS_SELECT_PIN,
  input  logic                              SUSPEND_SELECT_PIN,
  input  smbus_switch_pkg::fault_type       FAULT_IN,
  output smbus_switch_pkg::switch_ctrl_type CARD_A_CTRL,
  output smbus_switch_pkg::switch_ctrl_type CARD_B_CTRL
);
  import smbus_switch_pkg::*;

  typedef struct packed {
    logic                  scl_prev;
    logic                  sda_prev;
    bus_state_type         bus;
    logic [3:0]            cnt;
    logic [7:0]            shreg;
    logic [7:0]            rd_byte;
    target_type            target;
    logic                  ack_on;
    logic                  nack;
    logic                  sda_drive;
    logic [7:0]            op_a;
    logic [7:0]            op_b;
    logic [7:0]            sus_a;
    logic [7:0]            sus_b;
    fault_type             faults;
    logic                  alert;
    logic                  alert_chan_b;
    switch_ctrl_type [1:0] outs;
  } core_state_type;

  core_state_type        state;
  core_state_type        next_state;
  logic [8:0]            sync_q;
  logic                  scl;
  logic                  sda;
  logic                  susp_high;
  logic                  adr_sel;
  fault_type             live;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_det;
  logic                  stop_det;
  logic [7:0]            eff_cmd [2];
  switch_ctrl_type [1:0] decoded;
  logic [6:0]            addr_a;
  logic [6:0]            addr_b;
  logic                  fault_hit;

  pin_sync #(
    .WIDTH (`SYNC_WIDTH),
    .INIT  (`SYNC_INIT)
  ) u_sync (
    .CLK_SYS (CLK_SYS),
    .SYS_RST (SYS_RST),
    .pin_in  ({SMB_CLK, SMB_DATA_IN, SUSPEND_SELECT_PIN, ADDRESS_SELECT_PIN, FAULT_IN}),
    .pin_out (sync_q)
  );

  assign scl       = sync_q[8];
  assign sda       = sync_q[7];
  assign susp_high = sync_q[6];
  assign adr_sel   = sync_q[5];
  assign live      = sync_q[4:0];

  assign scl_rise  = scl & ~state.scl_prev;
  assign scl_fall  = ~scl & state.scl_prev;
  assign start_det = state.scl_prev & scl & state.sda_prev & ~sda;
  assign stop_det  = state.scl_prev & scl & ~state.sda_prev & sda;

  // Select level picks the address pair
  assign addr_a = {`CHAN_ADDR_HIGH, adr_sel, `CHAN_A_LSB};
  assign addr_b = {`CHAN_ADDR_HIGH, adr_sel, `CHAN_B_LSB};

  // Suspend pin chooses the latch set feeding the switches
  assign eff_cmd[0] = susp_high ? state.op_a : state.sus_a;
  assign eff_cmd[1] = susp_high ? state.op_b : state.sus_b;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      switch_decode u_decode (
        .cmd  (eff_cmd[ch]),
        .ctrl (decoded[ch])
      );
    end
  endgenerate

  // Only channel A bit 0 masks
  assign fault_hit = (|live) & ~eff_cmd[0][`CMD_MASK_BIT];

  always_comb begin
    logic       clear_faults;
    logic       clear_alert;
    logic [6:0] addr;
    logic       rw;
    clear_faults        = 1'b0;
    clear_alert         = 1'b0;
    addr                = state.shreg[6:0];
    rw                  = sda;
    next_state          = state;
    next_state.scl_prev = scl;
    next_state.sda_prev = sda;
    next_state.outs     = decoded;

    if (start_det) begin
      // Any unfinished byte is dropped here
      next_state.bus       = BUS_ADDR;
      next_state.cnt       = `BIT_COUNT_RESET;
      next_state.ack_on    = 1'b0;
      next_state.sda_drive = 1'b0;
      next_state.target    = TGT_NONE;
    end else if (stop_det) begin
      if (state.bus == BUS_WR_DONE) begin
        // Bit 7 routes the byte
        if (state.target == TGT_CMD_A) begin
          if (state.shreg[`CMD_OP_BIT]) begin
            next_state.op_a = state.shreg;
          end else begin
            next_state.sus_a = state.shreg;
          end
        end else if (state.target == TGT_CMD_B) begin
          if (state.shreg[`CMD_OP_BIT]) begin
            next_state.op_b = state.shreg;
          end else begin
            next_state.sus_b = state.shreg;
          end
        end
      end
      next_state.bus       = BUS_IDLE;
      next_state.sda_drive = 1'b0;
    end else begin
      case (state.bus)
        BUS_ADDR: begin
          if (scl_rise) begin
            next_state.shreg = {state.shreg[6:0], sda};
            next_state.cnt   = state.cnt + `BIT_COUNT_ONE;
            if (state.cnt == `LAST_BIT_INDEX) begin
              // Eighth bit is the direction
              next_state.bus = BUS_ADDR_ACK;
              if (addr == addr_a) begin
                next_state.target = rw ? TGT_FAULTS : TGT_CMD_A;
              end else if (addr == addr_b && !rw) begin
                next_state.target = TGT_CMD_B;
              end else if (addr == `POINTER_ADDR && rw && state.alert) begin
                next_state.target = TGT_POINTER;
              end else begin
                next_state.target = TGT_NONE;
                next_state.bus    = BUS_IGNORE;
              end
              if (addr == addr_a && rw) begin
                // Snapshot then clear; live faults relatch below
                next_state.rd_byte = {state.faults, `FAULT_TAIL};
                clear_faults       = 1'b1;
              end else if (addr == `POINTER_ADDR && rw && state.alert) begin
                next_state.rd_byte = {`CHAN_ADDR_HIGH, adr_sel, state.alert_chan_b, `POINTER_TAIL};
                clear_alert        = 1'b1;
              end
            end
          end
        end
        BUS_ADDR_ACK, BUS_WR_ACK: begin
          if (scl_fall) begin
            if (!state.ack_on) begin
              next_state.ack_on    = 1'b1;
              next_state.sda_drive = 1'b1;
            end else begin
              next_state.ack_on = 1'b0;
              next_state.cnt    = `BIT_COUNT_RESET;
              if (state.bus == BUS_WR_ACK) begin
                next_state.sda_drive = 1'b0;
                next_state.bus       = BUS_WR_DONE;
              end else if (state.target == TGT_FAULTS || state.target == TGT_POINTER) begin
                next_state.shreg     = state.rd_byte;
                next_state.sda_drive = ~state.rd_byte[7];
                next_state.bus       = BUS_RD_DATA;
              end else begin
                next_state.sda_drive = 1'b0;
                next_state.bus       = BUS_WR_DATA;
              end
            end
          end
        end
        BUS_WR_DATA: begin
          if (scl_rise) begin
            next_state.shreg = {state.shreg[6:0], sda};
            next_state.cnt   = state.cnt + `BIT_COUNT_ONE;
            if (state.cnt == `LAST_BIT_INDEX) begin
              next_state.bus = BUS_WR_ACK;
            end
          end
        end
        BUS_RD_DATA: begin
          if (scl_rise) begin
            next_state.cnt = state.cnt + `BIT_COUNT_ONE;
          end else if (scl_fall) begin
            // Data changes only after the clock has fallen
            if (state.cnt == `BYTE_BITS) begin
              next_state.sda_drive = 1'b0;
              next_state.bus       = BUS_RD_ACK;
            end else begin
              next_state.shreg     = {state.shreg[6:0], 1'b0};
              next_state.sda_drive = ~state.shreg[6];
            end
          end
        end
        BUS_RD_ACK: begin
          if (scl_rise) begin
            next_state.nack = sda;
          end else if (scl_fall) begin
            if (state.nack) begin
              next_state.bus = BUS_IGNORE;
            end else begin
              // Host asked for more: the same byte is repeated
              next_state.shreg     = state.rd_byte;
              next_state.sda_drive = ~state.rd_byte[7];
              next_state.cnt       = `BIT_COUNT_RESET;
              next_state.bus       = BUS_RD_DATA;
            end
          end
        end
        default: begin
          // Idle, ignoring and waiting for stop after the single byte
          next_state.sda_drive = 1'b0;
        end
      endcase
    end

    // Fault flags: new faults win over the read clear
    next_state.faults = (clear_faults ? `FAULT_RESET : state.faults) | live;
    // Alert latches even if the fault goes away
    next_state.alert  = (state.alert & ~clear_alert) | fault_hit;
    if (fault_hit && (!state.alert || clear_alert)) begin
      next_state.alert_chan_b = ~(live.catastrophic_fault | live.card_a_supply_fault | live.card_a_program_fault);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state              <= '0;
      state.scl_prev     <= 1'b1;
      state.sda_prev     <= 1'b1;
      state.bus          <= BUS_IDLE;
      state.target       <= TGT_NONE;
      state.op_a         <= `CMD_RESET;
      state.op_b         <= `CMD_RESET;
      state.sus_a        <= `CMD_RESET;
      state.sus_b        <= `CMD_RESET;
      state.faults       <= `FAULT_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign SMB_DATA_OUT  = 1'b0;
  assign SMB_DATA_OE_N = ~state.sda_drive;
  assign ALERT_OE_N    = ~state.alert;
  assign CARD_A_CTRL   = state.outs[0];
  assign CARD_B_CTRL   = state.outs[1];

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  a_start_detect: assert property (start_det |=> state.bus == BUS_ADDR && !state.sda_drive)
    else $error("start not taken");
  a_ignore_release: assert property (state.bus == BUS_IGNORE |-> !state.sda_drive)
    else $error("data driven while ignoring");
  a_dir_bit: assert property ((state.bus == BUS_ADDR && scl_rise && state.cnt == `LAST_BIT_INDEX && !start_det
    && !stop_det && state.shreg[6:0] == addr_b) |=> (state.target == TGT_CMD_B) == !$past(sda))
    else $error("direction bit misread");
  a_ack_drive: assert property ((state.bus inside {BUS_ADDR_ACK, BUS_WR_ACK}) && state.ack_on |-> state.sda_drive)
    else $error("acknowledge not driven");
  a_partial_drop: assert property ((stop_det && state.bus inside {BUS_WR_DATA, BUS_WR_ACK})
    |=> state.op_a == $past(state.op_a) && state.sus_a == $past(state.sus_a) && state.op_b == $past(state.op_b)
    && state.sus_b == $past(state.sus_b))
    else $error("partial byte changed a latch");
  a_commit_operate: assert property ((stop_det && state.bus == BUS_WR_DONE && state.target == TGT_CMD_A
    && state.shreg[`CMD_OP_BIT]) |=> state.op_a == $past(state.shreg))
    else $error("operate latch not loaded");
  a_commit_suspend: assert property ((stop_det && state.bus == BUS_WR_DONE && state.target == TGT_CMD_B
    && !state.shreg[`CMD_OP_BIT]) |=> state.sus_b == $past(state.shreg) && $stable(state.op_b))
    else $error("suspend latch not loaded");
  a_highz_wins: assert property (eff_cmd[0][`CMD_SUP_HIZ_BIT] |=> state.outs[0].card_supply == SUPPLY_HIGHZ)
    else $error("high impedance not applied");
  a_suspend_source: assert property ((!susp_high && state.sus_b[`CMD_SUP_ON_BIT] && !state.sus_b[`CMD_SUP_HIZ_BIT])
    |=> state.outs[1].card_supply != SUPPLY_GROUND)
    else $error("suspend latch not driving outputs");
  a_alert_hold: assert property ((state.alert && !(state.bus == BUS_ADDR && scl_rise && !start_det && !stop_det
    && state.cnt == `LAST_BIT_INDEX && state.shreg[6:0] == `POINTER_ADDR && sda)) |=> state.alert)
    else $error("alert dropped without service");
  a_alert_raise: assert property (fault_hit |=> !ALERT_OE_N)
    else $error("alert not raised");
  a_read_low_clock: assert property ((state.bus == BUS_RD_DATA && $changed(state.sda_drive)) |-> !scl)
    else $error("read data changed with clock high");

  c_write_commit: cover property (stop_det && state.bus == BUS_WR_DONE);
  c_pointer_read: cover property (state.bus == BUS_RD_DATA && state.target == TGT_POINTER);
  c_fault_read: cover property (state.bus == BUS_RD_ACK && state.target == TGT_FAULTS);
  c_ignore_addr: cover property (state.bus == BUS_IGNORE);
endmodule

// ### smbus_host_model.sv
// Behavioural SMBus host that drives the switch controller's link
`timescale 1ns/1ns
module smbus_host_model #(
  parameter int QUARTER = 30
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_wire
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Data moves a quarter period after the clock falls, well past the sync delay
  task automatic clock_bit(input logic drive, output logic seen);
    #QUARTER sda_low = ~drive;
    #QUARTER scl = 1'b1;
    #QUARTER seen = sda_wire;
    #QUARTER scl = 1'b0;
  endtask

  task automatic start_cond();
    #QUARTER sda_low = 1'b0;
    #QUARTER scl = 1'b1;
    #QUARTER sda_low = 1'b1;
    #QUARTER scl = 1'b0;
  endtask

  task automatic stop_cond();
    #QUARTER sda_low = 1'b1;
    #QUARTER scl = 1'b1;
    #QUARTER sda_low = 1'b0;
    #QUARTER;
  endtask

  // Short counts cut a byte off to provoke an abort
  task automatic write_bits(input logic [7:0] data, input int count, output logic ack);
    logic seen;
    ack = 1'b0;
    for (int i = 7; i > 7 - count; i--) begin
      clock_bit(data[i], seen);
    end
    if (count == 8) begin
      clock_bit(1'b1, seen);
      ack = ~seen;
    end
  endtask

  task automatic read_byte(input logic ack_it, output logic [7:0] data);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, data[i]);
    end
    clock_bit(~ack_it, seen);
  endtask
endmodule

// ### smbus_power_switch_ctrl_tb.sv
// Self-checking bench of the SMBus power-switch controller
`timescale 1ns/1ns
module smbus_power_switch_ctrl_tb;
  import smbus_switch_pkg::*;
  logic            clk_sys;
  logic            sys_rst;
  logic            addr_sel;
  logic            susp_sel;
  fault_type       fault_in;
  logic            scl;
  logic            sda_low;
  wire logic       sda_wire;
  logic            data_out;
  logic            data_oe_n;
  logic            alert_oe_n;
  switch_ctrl_type ctrl_a;
  switch_ctrl_type ctrl_b;
  int              err_total;
  int              check_count;
  logic [31:0]     lfsr_state;
  logic [7:0]      op_lat [2];
  logic [7:0]      sus_lat [2];
  logic [7:0]      exp_fault;

  // Open drain with pull-up: either party pulling low wins
  assign sda_wire = ~(sda_low | (~data_oe_n & ~data_out));

  smbus_power_switch_ctrl u_smbus_power_switch_ctrl (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SMB_CLK(scl), .SMB_DATA_IN(sda_wire),
    .SMB_DATA_OUT(data_out), .SMB_DATA_OE_N(data_oe_n), .ALERT_OE_N(alert_oe_n),
    .ADDRESS_SELECT_PIN(addr_sel), .SUSPEND_SELECT_PIN(susp_sel), .FAULT_IN(fault_in),
    .CARD_A_CTRL(ctrl_a), .CARD_B_CTRL(ctrl_b)
  );

  // Link slowed from 48 ns: the 3-stage sync needs phases of 4 cycles or more
  smbus_host_model u_smbus_host_model (.scl(scl), .sda_low(sda_low), .sda_wire(sda_wire));

  always #2 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] decode(input logic [7:0] c);
    logic [1:0] sup;
    logic [1:0] prg;
    sup = c[4] ? 2'h3 : (c[6] ? (c[5] ? 2'h2 : 2'h1) : 2'h0);
    prg = c[1] ? 2'h3 : (c[3] ? (c[2] ? 2'h2 : 2'h1) : 2'h0);
    return {4'h0, sup, prg};
  endfunction

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_outputs();
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys) susp_sel <= s[0];
      repeat (8) @(posedge clk_sys);
      check_byte({4'h0, ctrl_a}, decode(s[0] ? op_lat[0] : sus_lat[0]));
      check_byte({4'h0, ctrl_b}, decode(s[0] ? op_lat[1] : sus_lat[1]));
    end
  endtask

  task automatic smb_write(input logic [6:0] addr, input logic [7:0] cmd, input int count, input logic exp_ack);
    logic ack;
    u_smbus_host_model.start_cond();
    u_smbus_host_model.write_bits({addr, 1'b0}, 8, ack);
    check_flag(ack, exp_ack);
    u_smbus_host_model.write_bits(cmd, count, ack);
    if (count == 8) check_flag(ack, exp_ack);
    u_smbus_host_model.stop_cond();
    if (exp_ack && count == 8) begin
      if (cmd[7]) op_lat[addr[0]] = cmd;
      else sus_lat[addr[0]] = cmd;
    end
  endtask

  task automatic smb_read(input logic [6:0] addr, input logic exp_ack, input logic [7:0] exp_byte);
    logic       ack;
    logic [7:0] data;
    u_smbus_host_model.start_cond();
    u_smbus_host_model.write_bits({addr, 1'b1}, 8, ack);
    check_flag(ack, exp_ack);
    if (ack) begin
      u_smbus_host_model.read_byte(1'b0, data);
      check_byte(data, exp_byte);
    end
    u_smbus_host_model.stop_cond();
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    addr_sel = 1'b0;
    susp_sel = 1'b1;
    fault_in = '0;
    err_total = 0;
    check_count = 0;
    lfsr_state = 32'h0d4a;
    op_lat = '{8'h00, 8'h00};
    sus_lat = '{8'h00, 8'h00};
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check_flag(alert_oe_n, 1'b1);
    check_outputs();
    for (int n = 0; n < 16; n++) begin
      lfsr_state = lfsr_next(lfsr_state);
      @(posedge clk_sys) addr_sel <= n[3];
      repeat (6) @(posedge clk_sys);
      smb_write({5'h14, n[3], n[0]}, {n[1], lfsr_state[6:0]}, 8, 1'b1);
      check_outputs();
    end
    smb_write({5'h14, addr_sel, 1'b0}, 8'hff, 4, 1'b1);
    smb_write({5'h14, ~addr_sel, 1'b0}, 8'hff, 8, 1'b0);
    smb_write(7'h0c, 8'hff, 8, 1'b0);
    smb_read({5'h14, addr_sel, 1'b1}, 1'b0, 8'h00);
    check_outputs();
    @(posedge clk_sys) susp_sel <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      smb_write({5'h14, addr_sel, 1'b0}, {7'h60, k[1]}, 8, 1'b1);
      exp_fault = (k == 0) ? 8'h40 : ((k == 1) ? 8'h10 : 8'h20);
      @(posedge clk_sys) fault_in <= exp_fault[7:3];
      repeat (10) @(posedge clk_sys);
      check_flag(alert_oe_n, k[1]);
      @(posedge clk_sys) fault_in <= '0;
      repeat (10) @(posedge clk_sys);
      check_flag(alert_oe_n, k[1]);
      smb_read(7'h0c, ~k[1], {5'h14, addr_sel, k[0], 1'b0});
      check_flag(alert_oe_n, 1'b1);
      smb_read({5'h14, addr_sel, 1'b0}, 1'b1, exp_fault);
      smb_read({5'h14, addr_sel, 1'b0}, 1'b1, 8'h00);
    end
    final_report();
  end

  // About four times the expected run length
  initial begin
    #300000;
    err_total++;
    final_report();
  end
endmodule
